// ===== core/status_move_cfg.svh
// Constants for the status-transfer and multiply execute block.
// Assumes inclusion by bare name from the core/ folder.
`ifndef STATUS_MOVE_CFG_SVH
`define STATUS_MOVE_CFG_SVH

// ==========================================================
// Register bus offsets and fields
`define OFS_CTRL        8'h00
`define OFS_INFO        8'h04
`define OFS_CURRENT     8'h08
`define OFS_SAVED       8'h0C
`define CTRL_RUN_BIT    0
`define CTRL_RUN_RESET  1'h1
`define INFO_M_LSB      4

// ==========================================================
// Status word layout
`define PSW_IMPL_MASK   32'hF00000FF
`define PSW_RESET       32'h000000D3
`define PSW_N_BIT       31
`define PSW_Z_BIT       30
`define BANK_RESET      32'h00000000

// ==========================================================
// Mode codes
`define MODE_USER       5'h10
`define MODE_FIQ        5'h11
`define MODE_IRQ        5'h12
`define MODE_SVC        5'h13
`define MODE_ABT        5'h17
`define MODE_UND        5'h1B

// ==========================================================
// Multiplier array and saved-word banks
`define ARRAY_BITS      8
`define SAVED_BANKS     5

`endif

// ===== core/status_move_pkg.sv
// Types shared by the status-transfer and multiply execute block.
// Assumes nothing of its surroundings.
package status_move_pkg;

   typedef enum logic [1:0] {
      op_status_read,
      op_status_write,
      op_product_low,
      op_product_accumulate
   } exec_op_e;

   typedef enum logic [1:0] {
      st_idle,
      st_array,
      st_addend,
      st_finish
   } exec_state_e;

endpackage

// ===== core/booth_array_step.sv
// One pass of the multiplier array: adds multiplicand times a signed digit,
// shifted by whole digit positions, to the running low-word sum.
// Assumes the caller sequences the digits and keeps only the low word.
`timescale 1ns/1ps
`include "status_move_cfg.svh"

module booth_array_step #(
   parameter int unsigned ARRAY_W = `ARRAY_BITS,
   parameter int unsigned DATA_W  = 32
) (
   // Running sum and operands
   input  wire logic [DATA_W-1:0]  i_acc,
   input  wire logic [DATA_W-1:0]  i_mcand,
   input  wire logic [ARRAY_W:0]   i_digit,
   input  wire logic [1:0]         i_pos,
   // New sum
   output logic      [DATA_W-1:0]  o_sum
);

   logic [DATA_W-1:0] digit_ext;
   logic [DATA_W-1:0] part;
   logic [DATA_W-1:0] shifted;

   // The top digit bit is a sign, so a run of ones above it costs nothing.
   assign digit_ext = {{(DATA_W-ARRAY_W-1){i_digit[ARRAY_W]}}, i_digit};
   assign part      = i_mcand * digit_ext;
   assign shifted   = part << (32'(i_pos) * ARRAY_W);
   assign o_sum     = i_acc + shifted;

endmodule

// ===== core/status_move_and_multiply.sv
// Execute stage for status-word moves and 32-bit multiply/accumulate.
// Assumes decode supplies condition result and register operands.
`timescale 1ns/1ps
`include "status_move_cfg.svh"

module status_move_and_multiply #(
   parameter int unsigned BANKS = `SAVED_BANKS
) (
   // Clock and reset
   input  wire logic                      i_mclk,
   input  wire logic                      i_nrst,
   // Decoded instruction
   input  wire logic                      i_valid,
   input  wire status_move_pkg::exec_op_e i_op,
   input  wire logic                      i_cond_pass,
   input  wire logic                      i_set_flags,
   input  wire logic                      i_use_saved,
   input  wire logic                      i_flags_only,
   input  wire logic                      i_imm_sel,
   input  wire logic [31:0]               i_imm32,
   input  wire logic [3:0]                i_rd_idx,
   // Register operands
   input  wire logic [31:0]               i_multiplicand,
   input  wire logic [31:0]               i_multiplier,
   input  wire logic [31:0]               i_addend,
   // Results
   output logic                           o_ready,
   output logic                           o_done,
   output logic                           o_rf_we,
   output logic [3:0]                     o_rf_idx,
   output logic [31:0]                    o_rf_data,
   output logic [31:0]                    o_cur_status,
   // Wishbone slave
   input  wire logic                      i_wb_cyc,
   input  wire logic                      i_wb_stb,
   input  wire logic                      i_wb_we,
   input  wire logic [7:0]                i_wb_adr,
   input  wire logic [3:0]                i_wb_sel,
   input  wire logic [31:0]               i_wb_dat,
   output logic                           o_wb_dat_ack,
   output logic [31:0]                    o_wb_dat
);

   // ==========================================================
   // State
   status_move_pkg::exec_state_e state_reg, state_next;
   logic [31:0] cur_reg, cur_next;
   logic [31:0] bank_reg [BANKS];
   logic [31:0] mcand_reg, mplier_reg, addend_reg, acc_reg, acc_next;
   logic [1:0]  idx_reg;
   logic [2:0]  m_reg;
   logic        accum_reg, sflag_reg, run_reg, ready_reg, ack_reg;
   logic [3:0]  rd_reg;
   logic        rf_we_reg, done_reg;
   logic [3:0]  rf_idx_reg;
   logic [31:0] rf_data_reg, wb_dat_reg;
   logic [31:0] step_sum;

   // ==========================================================
   // Mode and saved-word selection
   wire [4:0] mode      = cur_reg[4:0];
   wire       is_user   = mode == `MODE_USER;
   wire       bank_hit  = mode == `MODE_FIQ || mode == `MODE_IRQ || mode == `MODE_SVC ||
                          mode == `MODE_ABT || mode == `MODE_UND;
   wire [2:0] bank_idx  = mode == `MODE_FIQ ? 3'h0 : mode == `MODE_IRQ ? 3'h1 :
                          mode == `MODE_SVC ? 3'h2 : mode == `MODE_ABT ? 3'h3 : 3'h4;
   // Modes without a saved word read back the current word.
   wire [31:0] saved_word = bank_hit ? bank_reg[bank_idx] : cur_reg;

   // ==========================================================
   // Instruction decode
   wire take      = i_valid & ready_reg;
   wire do_it     = take & i_cond_pass;
   wire st_read   = do_it & (i_op == status_move_pkg::op_status_read);
   wire st_write  = do_it & (i_op == status_move_pkg::op_status_write);
   wire is_acc_op = i_op == status_move_pkg::op_product_accumulate;
   wire mul_start = do_it & (is_acc_op | i_op == status_move_pkg::op_product_low);
   wire busy      = state_reg != status_move_pkg::st_idle;

   wire [31:0] psw_src   = i_imm_sel ? i_imm32 : i_multiplicand;
   wire whole_cur = st_write & ~i_use_saved & ~i_flags_only & ~is_user;
   wire flags_cur = st_write & ~i_use_saved & (i_flags_only | is_user);
   wire sav_we    = st_write & i_use_saved & bank_hit;
   wire [31:0] psw_whole = psw_src & `PSW_IMPL_MASK;
   wire [31:0] sav_wdata = i_flags_only ? {psw_src[31:28], saved_word[27:0]} : psw_whole;

   // ==========================================================
   // Multiplier sequencing
   // array count selection
   wire [2:0] m_calc =
      (&i_multiplier[31:8]  | ~|i_multiplier[31:8])  ? 3'h1 :
      (&i_multiplier[31:16] | ~|i_multiplier[31:16]) ? 3'h2 :
      (&i_multiplier[31:24] | ~|i_multiplier[31:24]) ? 3'h3 : 3'h4;
   wire       last_step = ({1'b0, idx_reg} + 3'h1) == m_reg;
   wire [7:0] cur_byte  = mplier_reg[{idx_reg, 3'h0} +: 8];
   wire [8:0] digit     = {last_step & mplier_reg[31], cur_byte};
   // Results leave at the edge that ends the last array or addend pass.
   wire       mul_end   = ((state_reg == status_move_pkg::st_array) & last_step & ~accum_reg) |
                          (state_reg == status_move_pkg::st_addend);
   wire       mul_flags = mul_end & sflag_reg;

   booth_array_step #(
      .ARRAY_W (`ARRAY_BITS),
      .DATA_W  (32)
   ) i_booth_array_step (
      .i_acc   (acc_reg),
      .i_mcand (mcand_reg),
      .i_digit (digit),
      .i_pos   (idx_reg),
      .o_sum   (step_sum)
   );

   always_comb begin
      case (state_reg)
         status_move_pkg::st_idle:
            state_next = mul_start ? status_move_pkg::st_array : status_move_pkg::st_idle;
         status_move_pkg::st_array:
            state_next = !last_step ? status_move_pkg::st_array :
                         accum_reg ? status_move_pkg::st_addend : status_move_pkg::st_idle;
         status_move_pkg::st_addend:
            state_next = status_move_pkg::st_idle;
         default:
            state_next = status_move_pkg::st_idle;
      endcase
   end

   assign acc_next = state_reg == status_move_pkg::st_array  ? step_sum :
                     state_reg == status_move_pkg::st_addend ? acc_reg + addend_reg :
                     acc_reg;

   assign cur_next = whole_cur ? psw_whole :
                     flags_cur ? {psw_src[31:28], cur_reg[27:0]} :
                     mul_flags ? {acc_next[31], acc_next == 32'h00000000, cur_reg[29:0]} :
                     cur_reg;

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         state_reg <= status_move_pkg::st_idle;
         cur_reg   <= `PSW_RESET;
         acc_reg   <= 32'h00000000;
         idx_reg   <= 2'h0;
      end else begin
         state_reg <= state_next;
         cur_reg   <= cur_next;
         acc_reg   <= mul_start ? 32'h00000000 : acc_next;
         idx_reg   <= state_reg == status_move_pkg::st_array ? idx_reg + 2'h1 : 2'h0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         mcand_reg  <= 32'h00000000;
         mplier_reg <= 32'h00000000;
         addend_reg <= 32'h00000000;
         m_reg      <= 3'h1;
         accum_reg  <= 1'b0;
         sflag_reg  <= 1'b0;
         rd_reg     <= 4'h0;
      end else if (mul_start) begin
         mcand_reg  <= i_multiplicand;
         mplier_reg <= i_multiplier;
         addend_reg <= i_addend;
         m_reg      <= m_calc;
         accum_reg  <= is_acc_op;
         sflag_reg  <= i_set_flags;
         rd_reg     <= i_rd_idx;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         for (int b = 0; b < BANKS; b++) begin
            bank_reg[b] <= `BANK_RESET;
         end
      end else if (sav_we) begin
         bank_reg[bank_idx] <= sav_wdata;
      end
   end

   // ==========================================================
   // Result port
   // read copies word
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         rf_we_reg   <= 1'b0;
         rf_idx_reg  <= 4'h0;
         rf_data_reg <= 32'h00000000;
         done_reg    <= 1'b0;
         ready_reg   <= 1'b0;
      end else begin
         rf_we_reg   <= st_read | mul_end;
         rf_idx_reg  <= st_read ? i_rd_idx : rd_reg;
         rf_data_reg <= st_read ? (i_use_saved ? saved_word : cur_reg) : acc_next;
         done_reg    <= (take & ~mul_start) | mul_end;
         ready_reg   <= (state_next == status_move_pkg::st_idle) & run_reg;
      end
   end

   // ==========================================================
   // Wishbone slave
   wire        wb_req   = i_wb_cyc & i_wb_stb & ~ack_reg;
   wire [7:0]  wb_ofs   = {i_wb_adr[7:2], 2'h0};
   wire [31:0] info_wd  = {25'h0000000, m_reg, 3'h0, busy};
   wire [31:0] wb_rdata = wb_ofs == `OFS_CTRL    ? {31'h00000000, run_reg} :
                          wb_ofs == `OFS_INFO    ? info_wd :
                          wb_ofs == `OFS_CURRENT ? cur_reg :
                          wb_ofs == `OFS_SAVED   ? saved_word : 32'h00000000;
   wire        run_wr   = wb_req & i_wb_we & i_wb_sel[0] & (wb_ofs == `OFS_CTRL);

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         ack_reg    <= 1'b0;
         wb_dat_reg <= 32'h00000000;
         run_reg    <= `CTRL_RUN_RESET;
      end else begin
         ack_reg    <= wb_req;
         wb_dat_reg <= wb_req ? wb_rdata : wb_dat_reg;
         run_reg    <= run_wr ? i_wb_dat[`CTRL_RUN_BIT] : run_reg;
      end
   end

   assign o_ready      = ready_reg;
   assign o_done       = done_reg;
   assign o_rf_we      = rf_we_reg;
   assign o_rf_idx     = rf_idx_reg;
   assign o_rf_data    = rf_data_reg;
   assign o_cur_status = cur_reg;
   assign o_wb_dat_ack = ack_reg;
   assign o_wb_dat     = wb_dat_reg;

   // ==========================================================
   // Checks
   logic [2:0]  lat_reg, exp_lat_reg;
   logic [31:0] exp_reg;

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         lat_reg     <= 3'h0;
         exp_lat_reg <= 3'h0;
         exp_reg     <= 32'h00000000;
      end else if (mul_start) begin
         lat_reg     <= 3'h0;
         exp_lat_reg <= m_calc + {2'h0, is_acc_op};
         exp_reg     <= i_multiplicand * i_multiplier + (is_acc_op ? i_addend : 32'h00000000);
      end else if (busy) begin
         lat_reg     <= lat_reg + 3'h1;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);

   a_reserved_zero: assert property ((cur_reg & ~`PSW_IMPL_MASK) == 32'h00000000)
      else $error("reserved status bits not zero");
   a_flags_write: assert property (flags_cur |=> cur_reg[31:28] == $past(psw_src[31:28])
      && cur_reg[27:0] == $past(cur_reg[27:0]))
      else $error("flags-only write wrong");
   a_user_whole_write: assert property (st_write && is_user && !i_use_saved |=> $stable(mode))
      else $error("user write changed control bits");
   a_priv_whole_write: assert property (whole_cur |=> cur_reg == $past(psw_whole))
      else $error("privileged whole write wrong");
   a_status_read: assert property (st_read |=> o_rf_we && o_done
      && o_rf_data == $past(i_use_saved ? saved_word : cur_reg))
      else $error("status read data or timing wrong");
   a_cond_fail: assert property (take && !i_cond_pass |=> $stable(cur_reg) && !o_rf_we
      && $stable(bank_reg[0]) && o_ready)
      else $error("failed condition changed state");
   a_mul_latency: assert property (mul_end |-> (lat_reg + 3'h1) == exp_lat_reg)
      else $error("multiply cycle count wrong");
   a_mul_result: assert property (mul_end |=> o_rf_we && o_rf_data == $past(exp_reg))
      else $error("multiply result wrong");
   a_mul_flags: assert property (mul_flags |=> cur_reg[31] == o_rf_data[31]
      && cur_reg[30] == (o_rf_data == 32'h00000000) && cur_reg[28] == $past(cur_reg[28]))
      else $error("multiply flags wrong");
   a_no_sflag: assert property (busy && !sflag_reg && !take |=> $stable(cur_reg))
      else $error("flags changed without set-flags");
   a_m_short: assert property (mul_start && i_multiplier[31:8] == 24'h000000 |=> m_reg == 3'h1)
      else $error("array count not shortened");

   c_mul_full: cover property (mul_start && m_calc == 3'h4 && !is_acc_op);
   c_mla_flags: cover property (mul_start && is_acc_op && i_set_flags);
   c_user_write: cover property (st_write && is_user);
   c_cond_fail: cover property (take && !i_cond_pass);

endmodule

// ===== test/status_move_and_multiply_bench.sv
// Self-checking bench for the status-transfer and multiply execute block.
// Assumes the design files under core/ and the header on the include path.
`timescale 1ns/1ps
`include "status_move_cfg.svh"

`define CHECK(nm, exp, got) begin \
   total_checks++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
   end \
end

module status_move_and_multiply_bench;
   localparam status_move_pkg::exec_op_e SR = status_move_pkg::op_status_read;
   localparam status_move_pkg::exec_op_e SW = status_move_pkg::op_status_write;
   localparam status_move_pkg::exec_op_e ML = status_move_pkg::op_product_low;
   localparam status_move_pkg::exec_op_e MA = status_move_pkg::op_product_accumulate;
   // Flag bits of a row: cond, set-flags, saved, flags-only, immediate.
   typedef struct {
      status_move_pkg::exec_op_e op;
      logic [4:0]                f;
      logic [31:0]               imm32;
      logic [31:0]               a;
      logic [31:0]               b;
      logic [31:0]               c;
   } row_s;

   logic                      i_mclk, i_nrst, i_valid, i_cond_pass, i_set_flags;
   logic                      i_use_saved, i_flags_only, i_imm_sel;
   status_move_pkg::exec_op_e i_op;
   logic [31:0]               i_imm32, i_multiplicand, i_multiplier, i_addend;
   logic [3:0]                i_rd_idx;
   logic                      o_ready, o_done, o_rf_we;
   logic [3:0]                o_rf_idx;
   logic [31:0]               o_rf_data, o_cur_status;
   logic                      i_wb_cyc, i_wb_stb, i_wb_we, o_wb_dat_ack;
   logic [7:0]                i_wb_adr;
   logic [3:0]                i_wb_sel;
   logic [31:0]               i_wb_dat, o_wb_dat, rd_word, exp_cur;
   logic [31:0]               exp_saved [32];
   int                        fail_count, total_checks, cycles;

   row_s rows [23] = '{
      '{SR, 5'h10, 32'h0, 32'h0, 32'h0, 32'h0},
      '{SW, 5'h12, 32'h0, 32'hA0000000, 32'h0, 32'h0},
      '{SW, 5'h13, 32'h50000000, 32'h0, 32'h0, 32'h0},
      '{ML, 5'h18, 32'h0, 32'hFFFFFFF6, 32'h14, 32'h0},
      '{ML, 5'h10, 32'h0, 32'h3, 32'h1234, 32'h0},
      '{ML, 5'h18, 32'h0, 32'h0, 32'h12000000, 32'h0},
      '{ML, 5'h10, 32'h0, 32'h7, 32'h00FF0000, 32'h0},
      '{ML, 5'h10, 32'h0, 32'h5, 32'hFFFFFF00, 32'h0},
      '{MA, 5'h18, 32'h0, 32'h3, 32'h5, 32'h7},
      '{MA, 5'h10, 32'h0, 32'hFFFFFFFF, 32'h80000001, 32'h1},
      '{ML, 5'h08, 32'h0, 32'h0, 32'h5, 32'h0},
      '{SW, 5'h00, 32'h0, 32'h0, 32'h0, 32'h0},
      '{SW, 5'h14, 32'h0, 32'hFFFFFFFF, 32'h0, 32'h0},
      '{SR, 5'h14, 32'h0, 32'h0, 32'h0, 32'h0},
      '{SW, 5'h17, 32'h30000000, 32'h0, 32'h0, 32'h0},
      '{SR, 5'h14, 32'h0, 32'h0, 32'h0, 32'h0},
      '{SW, 5'h10, 32'h0, 32'h000000D2, 32'h0, 32'h0},
      '{SR, 5'h14, 32'h0, 32'h0, 32'h0, 32'h0},
      '{SW, 5'h10, 32'h0, 32'h90000010, 32'h0, 32'h0},
      '{SW, 5'h10, 32'h0, 32'h6000001F, 32'h0, 32'h0},
      '{SW, 5'h14, 32'h0, 32'hFFFFFFFF, 32'h0, 32'h0},
      '{SR, 5'h14, 32'h0, 32'h0, 32'h0, 32'h0},
      '{SR, 5'h10, 32'h0, 32'h0, 32'h0, 32'h0}
   };

   status_move_and_multiply i_status_move_and_multiply (
      .i_mclk(i_mclk), .i_nrst(i_nrst), .i_valid(i_valid), .i_op(i_op),
      .i_cond_pass(i_cond_pass), .i_set_flags(i_set_flags), .i_use_saved(i_use_saved),
      .i_flags_only(i_flags_only), .i_imm_sel(i_imm_sel), .i_imm32(i_imm32),
      .i_rd_idx(i_rd_idx), .i_multiplicand(i_multiplicand), .i_multiplier(i_multiplier),
      .i_addend(i_addend), .o_ready(o_ready), .o_done(o_done), .o_rf_we(o_rf_we),
      .o_rf_idx(o_rf_idx), .o_rf_data(o_rf_data), .o_cur_status(o_cur_status),
      .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
      .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat_ack(o_wb_dat_ack),
      .o_wb_dat(o_wb_dat));

   initial begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end

   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   function automatic int mcount(input logic [31:0] b);
      if (&b[31:8] || ~|b[31:8]) return 1;
      if (&b[31:16] || ~|b[31:16]) return 2;
      if (&b[31:24] || ~|b[31:24]) return 3;
      return 4;
   endfunction

   function automatic logic has_bank(input logic [4:0] md);
      return md inside {`MODE_FIQ, `MODE_IRQ, `MODE_SVC, `MODE_ABT, `MODE_UND};
   endfunction

   task automatic wb_access(input logic we, input logic [7:0] adr, input logic [31:0] wdat);
      int n;
      @(posedge i_mclk);
      i_wb_cyc <= 1'h1;
      i_wb_stb <= 1'h1;
      i_wb_we  <= we;
      i_wb_adr <= adr;
      i_wb_dat <= wdat;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_wb_dat_ack !== 1'h1 && n < 50);
      if (o_wb_dat_ack !== 1'h1) fail_count++;
      rd_word = o_wb_dat;
      i_wb_cyc <= 1'h0;
      i_wb_stb <= 1'h0;
      @(posedge i_mclk);
   endtask

   task automatic run_row(input row_s r, input logic [3:0] idx);
      logic [31:0] src, res, e_data;
      logic [4:0]  md;
      logic        mul, e_we;
      int          lat, n;
      md = exp_cur[4:0];
      src = r.f[0] ? r.imm32 : r.a;
      mul = (r.op == ML) || (r.op == MA);
      res = r.a * r.b + ((r.op == MA) ? r.c : 32'h0);
      e_we = r.f[4] && (r.op != SW);
      e_data = res;
      lat = 1;
      if (r.f[4] && r.op == SR) e_data = (r.f[2] && has_bank(md)) ? exp_saved[md] : exp_cur;
      if (r.f[4] && mul) lat = mcount(r.b) + ((r.op == MA) ? 2 : 1);
      if (r.f[4] && mul && r.f[3]) exp_cur[31:30] = {res[31], res == 32'h0};
      if (r.f[4] && r.op == SW && r.f[2] && has_bank(md)) begin
         if (r.f[1]) exp_saved[md][31:28] = src[31:28];
         else exp_saved[md] = src & `PSW_IMPL_MASK;
      end
      if (r.f[4] && r.op == SW && !r.f[2]) begin
         if (r.f[1] || md == `MODE_USER) exp_cur[31:28] = src[31:28];
         else exp_cur = src & `PSW_IMPL_MASK;
      end
      do @(posedge i_mclk); while (o_ready !== 1'h1);
      {i_cond_pass, i_set_flags, i_use_saved, i_flags_only, i_imm_sel} <= r.f;
      i_valid <= 1'h1;
      i_op <= r.op;
      i_imm32 <= r.imm32;
      i_multiplicand <= r.a;
      i_multiplier <= r.b;
      i_addend <= r.c;
      i_rd_idx <= idx;
      @(posedge i_mclk);
      i_valid <= 1'h0;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
         if (o_done !== 1'h1 && mul) `CHECK("ready while busy", 1'h0, o_ready)
      end while (o_done !== 1'h1 && n < 12);
      `CHECK("latency", lat, n)
      `CHECK("rf write", e_we, o_rf_we)
      if (e_we) `CHECK("rf data", e_data, o_rf_data)
      if (e_we) `CHECK("rf index", idx, o_rf_idx)
      `CHECK("status", exp_cur, o_cur_status)
   endtask

   initial begin
      {i_nrst, i_valid, i_cond_pass, i_set_flags, i_use_saved} = 5'h0;
      {i_flags_only, i_imm_sel, i_wb_cyc, i_wb_stb, i_wb_we} = 5'h0;
      i_op = SR;
      {i_imm32, i_multiplicand, i_multiplier, i_addend, i_wb_dat} = '0;
      i_rd_idx = 4'h0;
      i_wb_adr = 8'h00;
      i_wb_sel = 4'hF;
      exp_cur = `PSW_RESET;
      foreach (exp_saved[k]) exp_saved[k] = `BANK_RESET;
      repeat (5) @(posedge i_mclk);
      `CHECK("ready in reset", 1'h0, o_ready)
      `CHECK("reset status", `PSW_RESET, o_cur_status)
      i_nrst <= 1'h1;
      wb_access(1'h0, `OFS_CTRL, 32'h0);
      `CHECK("ctrl reset", 32'h1, rd_word)
      foreach (rows[i]) run_row(rows[i], {1'b0, i[2:0]});
      wb_access(1'h0, `OFS_CURRENT, 32'h0);
      `CHECK("bus current", exp_cur, rd_word)
      wb_access(1'h1, `OFS_CURRENT, 32'hFFFFFFFF);
      wb_access(1'h0, `OFS_CURRENT, 32'h0);
      `CHECK("read-only word", exp_cur, rd_word)
      wb_access(1'h0, 8'h10, 32'h0);
      `CHECK("unmapped", 32'h0, rd_word)
      wb_access(1'h1, `OFS_CTRL, 32'h0);
      @(posedge i_mclk);
      `CHECK("halted ready", 1'h0, o_ready)
      wb_access(1'h1, `OFS_CTRL, 32'h1);
      run_row(rows[0], 4'h7);
      i_nrst <= 1'h0;
      repeat (2) @(posedge i_mclk);
      i_nrst <= 1'h1;
      exp_cur = `PSW_RESET;
      foreach (exp_saved[k]) exp_saved[k] = `BANK_RESET;
      wb_access(1'h0, `OFS_SAVED, 32'h0);
      `CHECK("saved after reset", `BANK_RESET, rd_word)
      run_row(rows[13], 4'h3);
      end_of_test();
   end
endmodule
